// File: include/clkcfg_pkg.sv
/*
 * Package for the clock generator configuration slice at bytes 1ah..21h:
 * byte offsets, reset values, field positions, struct carriers and modes.
 * Assumes the serial management block delivers a byte address, write
 * strobe and data on the same clock as this slice.
 */
package clkcfg_pkg;

  // byte offsets
  localparam logic [7:0] ADDR_REF_DIV = 8'h1a;
  localparam logic [7:0] ADDR_OUT_DIV = 8'h1b;
  localparam logic [7:0] ADDR_PLL_OP = 8'h1c;
  localparam logic [7:0] ADDR_SUPPLY = 8'h1d;
  localparam logic [7:0] ADDR_PIN_FREQ = 8'h1e;
  localparam logic [7:0] ADDR_LOOP_CTL = 8'h1f;
  localparam logic [7:0] ADDR_FREQ_EN = 8'h20;
  localparam logic [7:0] ADDR_OUT3_CTL = 8'h21;
  localparam int NUM_REGS = 8;

  // reset values; reserved bits with no printed default reset to zero
  localparam logic [7:0] RST_REF_DIV = 8'h1a;
  localparam logic [7:0] RST_OUT_DIV = 8'h23;
  localparam logic [7:0] RST_PLL_OP = 8'h0c;
  localparam logic [7:0] RST_SUPPLY = 8'h00;
  localparam logic [7:0] RST_PIN_FREQ = 8'h88;
  localparam logic [7:0] RST_LOOP_CTL = 8'h84;
  localparam logic [7:0] RST_FREQ_EN = 8'hc0;
  localparam logic [7:0] RST_OUT3_CTL = 8'h80;

  // field positions
  localparam int BIT_DOUBLER = 7;
  localparam int BIT_BYP_ONE = 6;
  localparam int BIT_BYP_TWO = 5;
  localparam int REF_DIV_MSB = 4;
  localparam int BIT_FINE_RES = 7;
  localparam int BIT_REF_SRC = 6;
  localparam int BIT_SUPPLY = 2;
  localparam int BIT_FIRST_OUTPUT_ENABLE = 7;
  localparam int PIN_SEL_LSB = 5;
  localparam int BIT_OUT2_STOP = 7;
  localparam int BIT_LOOP_ORDER = 2;
  localparam int BIT_DIV5_SRC = 1;
  localparam int BIT_EXTRA_POLE = 0;
  localparam int BIT_OUT2_INDEP = 6;
  localparam int BIT_DYNAMIC_FREQ_SWITCH_ENABLE = 4;
  localparam int BIT_OUT3_STOP = 7;

  // reference divider range
  localparam logic [6:0] REF_DIV_MIN = 7'h03;
  localparam logic [6:0] REF_DIV_MAX = 7'h40;
  localparam int FINE_SHIFT = 4;

  typedef enum logic [1:0] {
    PIN_OUT1_OE,
    PIN_POWERDOWN_N,
    PIN_POWER_SAVE_OUT,
    PIN_FREQ_SELECT
  } pin_mode_t;

  typedef struct packed {
    logic doubler_en;
    logic bypass_one;
    logic bypass_two;
    logic [6:0] divide_value;
    logic divide_ok;
  } ref_path_t;

  typedef struct packed {
    logic [3:0] prescale;
    logic [3:0] postscale;
    logic [6:0] total;
  } out_div_t;

  typedef struct packed {
    logic [2:0] run;
    logic [2:0] lock_use;
  } loop_power_t;

  typedef struct packed {
    logic fine_res;
    logic [2:0] step_shift;
    logic ref_from_second_output_divider;
    logic third_order;
    logic extra_pole;
    logic fifth_src_seed;
  } loop_ctl_t;

  typedef struct packed {
    logic out1_enable;
    logic out2_enable;
    logic out3_enable;
    logic out2_stoppable;
    logic out3_stoppable;
    logic supply_low;
    logic [1:0] freq_set;
    logic powerdown;
    logic power_save_out;
  } out_ctl_t;

endpackage : clkcfg_pkg

// File: verilog/clkcfg_regs.sv
/*
 * Configuration register slice, bytes 1ah..21h, and the decode of its
 * fields into control words for the dividers, loops and outputs.
 * Assumes a byte-wide register port from the serial management logic on
 * the same clock, and the multifunction pin arriving asynchronously.
 */
`timescale 1ns/10ps

module clkcfg_regs #(
  parameter int NUM_LOOPS = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // multifunction pin, three signals
  input wire logic multifunction_enable_pin_in,
  output logic multifunction_enable_pin_out,
  output logic multifunction_enable_pin_oe,
  // second frequency select input from elsewhere on chip
  input wire logic freq_select_input_one,
  // decoded controls
  output clkcfg_pkg::ref_path_t ref_path,
  output clkcfg_pkg::out_div_t third_out_divide_field,
  output clkcfg_pkg::out_div_t fourth_out_divide_field,
  output clkcfg_pkg::loop_power_t loop_power,
  output clkcfg_pkg::loop_ctl_t loop_ctl,
  output clkcfg_pkg::out_ctl_t out_ctl,
  output clkcfg_pkg::pin_mode_t pin_mode
);

  initial begin
    if (NUM_LOOPS != 3) begin
      $error("clkcfg_regs serves exactly three loops");
    end
  end

  localparam logic [7:0] RST_VALS [clkcfg_pkg::NUM_REGS] = '{
    clkcfg_pkg::RST_REF_DIV, clkcfg_pkg::RST_OUT_DIV,
    clkcfg_pkg::RST_PLL_OP, clkcfg_pkg::RST_SUPPLY,
    clkcfg_pkg::RST_PIN_FREQ, clkcfg_pkg::RST_LOOP_CTL,
    clkcfg_pkg::RST_FREQ_EN, clkcfg_pkg::RST_OUT3_CTL};

  logic [7:0] regs_ff [clkcfg_pkg::NUM_REGS];
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic [2:0] idx;
  logic in_range;

  // prescale 1,2,4,8 times postscale 1,3,5,10
  function automatic clkcfg_pkg::out_div_t decode_div(input logic [3:0] f);
    clkcfg_pkg::out_div_t d;
    d = '0;
    d.prescale = 4'h1 << f[3:2];
    unique case (f[1:0])
      2'h0: d.postscale = 4'h1;
      2'h1: d.postscale = 4'h3;
      2'h2: d.postscale = 4'h5;
      2'h3: d.postscale = 4'ha;
    endcase
    d.total = 7'(d.prescale * d.postscale);
    return d;
  endfunction : decode_div

  assign in_range = (reg_addr >= clkcfg_pkg::ADDR_REF_DIV) &&
                    (reg_addr <= clkcfg_pkg::ADDR_OUT3_CTL);
  assign idx = 3'(reg_addr - clkcfg_pkg::ADDR_REF_DIV);
  assign reg_hit = in_range;

  // whole bytes stored; reserved bits hold whatever software writes back
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < clkcfg_pkg::NUM_REGS; i++) begin
        regs_ff[i] <= RST_VALS[i];
      end
    end else if (reg_wr && in_range) begin
      regs_ff[idx] <= reg_wdata;
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= in_range ? regs_ff[idx] : 8'h00;
    end
  end

  // pin crosses in through two flops
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= multifunction_enable_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  logic [7:0] r_ref;
  logic [7:0] r_div;
  logic [7:0] r_op;
  logic [7:0] r_pin;
  logic [7:0] r_loop;
  logic [7:0] r_fen;
  logic [6:0] raw_div;
  logic dfc_on;
  logic all_loops_down;
  logic out1_oe_allow;
  logic [1:0] nxt_freq;
  clkcfg_pkg::out_ctl_t nxt_out;

  assign r_ref = regs_ff[0];
  assign r_div = regs_ff[1];
  assign r_op = regs_ff[2];
  assign r_pin = regs_ff[4];
  assign r_loop = regs_ff[5];
  assign r_fen = regs_ff[6];
  assign pin_mode = clkcfg_pkg::pin_mode_t'(r_pin[clkcfg_pkg::PIN_SEL_LSB+:2]);
  assign dfc_on = r_fen[clkcfg_pkg::BIT_DYNAMIC_FREQ_SWITCH_ENABLE];

  // zero field means 32, giving the 1..32 span
  assign raw_div = (r_ref[clkcfg_pkg::REF_DIV_MSB:0] == 5'h00) ? 7'h20 :
                   {2'b00, r_ref[clkcfg_pkg::REF_DIV_MSB:0]};

  always_comb begin
    ref_path = '0;
    ref_path.doubler_en = r_ref[clkcfg_pkg::BIT_DOUBLER];
    ref_path.bypass_one = r_ref[clkcfg_pkg::BIT_BYP_ONE];
    ref_path.bypass_two = r_ref[clkcfg_pkg::BIT_BYP_TWO];
    ref_path.divide_value = raw_div;
    ref_path.divide_ok = (raw_div >= clkcfg_pkg::REF_DIV_MIN) &&
                         (raw_div <= clkcfg_pkg::REF_DIV_MAX);
  end

  assign third_out_divide_field = decode_div(r_div[7:4]);
  assign fourth_out_divide_field = decode_div(r_div[3:0]);

  // run bits at odd positions, lock-use at even
  for (genvar g = 0; g < NUM_LOOPS; g++) begin : g_loop
    assign loop_power.run[g] = r_op[2*g+1];
    assign loop_power.lock_use[g] = r_op[2*g];
  end

  always_comb begin
    loop_ctl = '0;
    loop_ctl.fine_res = r_op[clkcfg_pkg::BIT_FINE_RES];
    loop_ctl.step_shift = loop_ctl.fine_res ?
      3'(clkcfg_pkg::FINE_SHIFT) : 3'h0;
    loop_ctl.ref_from_second_output_divider = r_op[clkcfg_pkg::BIT_REF_SRC];
    loop_ctl.third_order = r_loop[clkcfg_pkg::BIT_LOOP_ORDER];
    loop_ctl.extra_pole = r_loop[clkcfg_pkg::BIT_EXTRA_POLE];
    loop_ctl.fifth_src_seed = r_loop[clkcfg_pkg::BIT_DIV5_SRC];
  end

  assign all_loops_down = ~|loop_power.run;

  // pin enables the first output, and the second unless independent, only in enable mode
  assign out1_oe_allow = (pin_mode != clkcfg_pkg::PIN_OUT1_OE) || pin_sync_ff;

  always_comb begin
    nxt_out = '0;
    nxt_freq = r_pin[1:0];
    if (dfc_on && pin_mode == clkcfg_pkg::PIN_FREQ_SELECT) begin
      nxt_freq = {freq_select_input_one, pin_sync_ff};
    end
    nxt_out.freq_set = nxt_freq;
    nxt_out.powerdown = (pin_mode == clkcfg_pkg::PIN_POWERDOWN_N) &&
                        !pin_sync_ff;
    nxt_out.power_save_out = all_loops_down || nxt_out.powerdown;
    nxt_out.out1_enable = r_pin[clkcfg_pkg::BIT_FIRST_OUTPUT_ENABLE] && out1_oe_allow &&
                          !nxt_out.powerdown;
    nxt_out.out2_enable = !nxt_out.powerdown &&
      (r_fen[clkcfg_pkg::BIT_OUT2_INDEP] || out1_oe_allow);
    nxt_out.out3_enable = !nxt_out.powerdown;
    nxt_out.out2_stoppable = r_loop[clkcfg_pkg::BIT_OUT2_STOP];
    nxt_out.out3_stoppable = regs_ff[7][clkcfg_pkg::BIT_OUT3_STOP];
    nxt_out.supply_low = regs_ff[3][clkcfg_pkg::BIT_SUPPLY];
  end

  // outputs registered to keep pin glitches off the output gating
  always_ff @(posedge clock) begin
    if (rst) begin
      out_ctl <= '0;
    end else begin
      out_ctl <= nxt_out;
    end
  end

  // pin drives out only in power saving mode
  always_ff @(posedge clock) begin
    if (rst) begin
      multifunction_enable_pin_out <= 1'b0;
      multifunction_enable_pin_oe <= 1'b0;
    end else begin
      multifunction_enable_pin_out <= nxt_out.power_save_out;
      multifunction_enable_pin_oe <=
        (pin_mode == clkcfg_pkg::PIN_POWER_SAVE_OUT);
    end
  end

endmodule : clkcfg_regs

// File: bench/clkcfg_regs_sva.sv
/* Checker for clkcfg_regs: write-to-field and read port relations.
   Assumes it is bound to each clkcfg_regs instance. */
`timescale 1ns/10ps
module clkcfg_regs_sva #(
  parameter int NUM_LOOPS = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  // decoded controls
  input wire clkcfg_pkg::ref_path_t ref_path,
  input wire clkcfg_pkg::loop_power_t loop_power,
  input wire clkcfg_pkg::loop_ctl_t loop_ctl,
  input wire clkcfg_pkg::out_ctl_t out_ctl,
  input wire clkcfg_pkg::pin_mode_t pin_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_ref_bits: assert property (
    reg_wr && reg_addr == 8'h1a |=> ref_path.doubler_en == $past(reg_wdata[7])
    && {ref_path.bypass_one, ref_path.bypass_two} == $past(reg_wdata[6:5]))
    else $error("reference path bits differ from written byte");
  a_ref_range: assert property (
    reg_wr && reg_addr == 8'h1a |=> ref_path.divide_ok ==
    ($past(reg_wdata[4:0]) == 5'h00 || $past(reg_wdata[4:0]) > 5'h02))
    else $error("reference divide range flag wrong");
  a_loop_power: assert property (
    reg_wr && reg_addr == 8'h1c |=> loop_power ==
    {$past(reg_wdata[5]), $past(reg_wdata[3]), $past(reg_wdata[1]),
    $past(reg_wdata[4]), $past(reg_wdata[2]), $past(reg_wdata[0])})
    else $error("loop run or lock bits wrong");
  a_spread_src: assert property (
    reg_wr && reg_addr == 8'h1c |=> loop_ctl.fine_res == $past(reg_wdata[7])
    && loop_ctl.step_shift == ($past(reg_wdata[7]) ? 3'h4 : 3'h0)
    && loop_ctl.ref_from_second_output_divider == $past(reg_wdata[6]))
    else $error("spread shift or reference source wrong");
  a_pin_mode: assert property (
    reg_wr && reg_addr == 8'h1e |=> pin_mode == $past(reg_wdata[6:5]))
    else $error("multifunction pin mode wrong");
  a_loop_order: assert property (
    reg_wr && reg_addr == 8'h1f |=> loop_ctl.third_order == $past(reg_wdata[2])
    && loop_ctl.extra_pole == $past(reg_wdata[0]))
    else $error("loop order or extra pole wrong");
  a_out2_stop: assert property (
    reg_wr && reg_addr == 8'h1f ##1 !rst |=> out_ctl.out2_stoppable ==
    $past(reg_wdata[7], 2))
    else $error("second output stoppable wrong");
  a_out3_stop: assert property (
    reg_wr && reg_addr == 8'h21 ##1 !rst |=> out_ctl.out3_stoppable ==
    $past(reg_wdata[7], 2))
    else $error("third output stoppable wrong");
  a_unmapped_rd: assert property (
    !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_div_write: cover property (reg_wr && reg_addr == 8'h1b);
  c_save_mode: cover property (pin_mode == clkcfg_pkg::PIN_POWER_SAVE_OUT);
  c_unmapped: cover property (!reg_hit ##1 reg_rdata == 8'h00);
endmodule : clkcfg_regs_sva

bind clkcfg_regs clkcfg_regs_sva #(.NUM_LOOPS(NUM_LOOPS)) sva_inst (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .ref_path(ref_path), .loop_power(loop_power), .loop_ctl(loop_ctl),
  .out_ctl(out_ctl), .pin_mode(pin_mode));

// File: bench/clkcfg_regs_test.sv
/* Bench for clkcfg_regs: reset values, read-back, divider decode, pin modes.
   Assumes the package is compiled first and the checker is bound. */
`timescale 1ns/10ps
module clkcfg_regs_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic pin_in = 1'b1;
  logic sel_one = 1'b0;
  logic [7:0] reg_rdata, v;
  logic reg_hit, pin_out, pin_oe;
  clkcfg_pkg::ref_path_t ref_path;
  clkcfg_pkg::out_div_t div3, div4;
  clkcfg_pkg::loop_power_t loop_power;
  clkcfg_pkg::loop_ctl_t loop_ctl;
  clkcfg_pkg::out_ctl_t out_ctl;
  clkcfg_pkg::pin_mode_t pin_mode;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] rst_val [8] = '{8'h1a, 8'h23, 8'h0c, 8'h00, 8'h88, 8'h84,
    8'hc0, 8'h80};
  // address, byte written, byte read back; 19h and 22h are unmapped
  logic [23:0] rows [7] = '{24'h1a4545, 24'h1dffff, 24'h1f7b7b, 24'h200000,
    24'h217f7f, 24'h225a00, 24'h19a500};
  logic [7:0] post [4] = '{8'h01, 8'h03, 8'h05, 8'h0a};

  clkcfg_regs clkcfg_regs_inst (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .multifunction_enable_pin_in(pin_in),
    .multifunction_enable_pin_out(pin_out),
    .multifunction_enable_pin_oe(pin_oe), .freq_select_input_one(sel_one),
    .ref_path(ref_path), .third_out_divide_field(div3),
    .fourth_out_divide_field(div4), .loop_power(loop_power),
    .loop_ctl(loop_ctl), .out_ctl(out_ctl), .pin_mode(pin_mode));

  always #5 clock = ~clock;

  task automatic check(input string name, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // every task starts and ends 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    cyc(1);
    v = reg_rdata;
  endtask : rd
  task automatic reset_check();
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(8'h1a + 8'(i));
      check("reset byte", v, rst_val[i]);
    end
    check("divide value", {1'b0, ref_path.divide_value}, 8'h1a);
    check("loop power", {2'b00, loop_power}, 8'h12);
  endtask : reset_check

  initial begin
    #100000;
    bad_count++;
    end_sim();
  end

  initial begin
    #1;
    reset_check();
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      check("read back", v, rows[i][7:0]);
    end
    wr(8'h1a, 8'h00);
    check("divide zero", {1'b0, ref_path.divide_value}, 8'h20);
    for (int i = 0; i < 16; i++) begin
      wr(8'h1b, {4'(i), ~4'(i)});
      check("third div", {1'b0, div3.total},
        (8'h01 << i[3:2]) * post[i[1:0]]);
      check("fourth div", {1'b0, div4.total},
        (8'h01 << (~i[3:2] & 2'h3)) * post[~i[1:0] & 2'h3]);
    end
    for (int k = 0; k < 4; k++) begin
      wr(8'h1e, 8'h88 | 8'(k));
      cyc(1);
      check("soft freq set", {6'h00, out_ctl.freq_set}, 8'(k));
    end
    wr(8'h1e, 8'h20);
    cyc(1);
    check("out1 off", {7'h00, out_ctl.out1_enable}, 8'h00);
    wr(8'h1e, 8'ha0);
    cyc(1);
    check("out1 on", {7'h00, out_ctl.out1_enable}, 8'h01);
    pin_in = 1'b0;
    cyc(4);
    check("pin powerdown", {7'h00, out_ctl.powerdown}, 8'h01);
    check("powered out1", {7'h00, out_ctl.out1_enable}, 8'h00);
    wr(8'h1e, 8'h80);
    wr(8'h20, 8'h80);
    cyc(2);
    check("out2 gated", {7'h00, out_ctl.out2_enable}, 8'h00);
    wr(8'h20, 8'hc0);
    cyc(1);
    check("out2 free", {7'h00, out_ctl.out2_enable}, 8'h01);
    pin_in = 1'b1;
    sel_one = 1'b1;
    wr(8'h1e, 8'he0);
    wr(8'h20, 8'hd0);
    cyc(4);
    check("pin freq set", {6'h00, out_ctl.freq_set}, 8'h03);
    wr(8'h1e, 8'hc0);
    wr(8'h1c, 8'h00);
    cyc(3);
    check("save pin drive", {6'h00, pin_oe, pin_out}, 8'h03);
    reset_check();
    end_sim();
  end
endmodule : clkcfg_regs_test
